// ---- pkg/lcdsb_pkg.sv ----
// Package: register map, field layout and timing of the LCD blink/segment block
package lcdsb_pkg;

  // Printed offsets are register indices; byte address is four times these
  localparam logic [15:0] LCDSB_IDX_BLINK_LO = 16'h0fb9;
  localparam logic [15:0] LCDSB_IDX_BLINK_HI = 16'h0fba;
  localparam logic [15:0] LCDSB_IDX_RAM_BASE = 16'h0fbd;
  localparam logic [15:0] LCDSB_IDX_PIN_SEL  = 16'h0fe0;
  localparam logic [15:0] LCDSB_IDX_CTRL     = 16'h0fe1;
  localparam logic [15:0] LCDSB_IDX_STATUS   = 16'h0fe2;

  // Display RAM depth in eight-common and four-common mode
  localparam int unsigned LCDSB_RAM_BYTES_8COM = 28;
  localparam int unsigned LCDSB_RAM_BYTES_4COM = 16;
  localparam int unsigned LCDSB_BLINK_DOTS     = 16;

  // Control register field positions
  localparam int unsigned LCDSB_CTRL_FOUR_COM_BIT  = 0;
  localparam int unsigned LCDSB_CTRL_PIN_IF_BIT    = 1;
  localparam int unsigned LCDSB_CTRL_BLINK_SEL_BIT = 2;

  // Status register field positions
  localparam int unsigned LCDSB_STAT_PHASE_BIT  = 0;
  localparam int unsigned LCDSB_STAT_SEG_EN_LSB = 8;

  // Reset values
  localparam logic [7:0] LCDSB_RST_BYTE = 8'h00;
  localparam logic [2:0] LCDSB_RST_CTRL = 3'h0;

  // Blink half-periods in milliseconds and derived cycle counts at pclk
  localparam int unsigned LCDSB_CLK_MHZ       = 100;
  localparam int unsigned LCDSB_BLINK_FAST_MS = 250;
  localparam int unsigned LCDSB_BLINK_SLOW_MS = 500;
  localparam int unsigned LCDSB_BLINK_FAST_CYC =
    LCDSB_BLINK_FAST_MS * 1000 * LCDSB_CLK_MHZ;
  localparam int unsigned LCDSB_BLINK_SLOW_CYC =
    LCDSB_BLINK_SLOW_MS * 1000 * LCDSB_CLK_MHZ;

  typedef struct packed {
    logic blink_interval_select;
    logic pin_interface_control;
    logic four_com;
  } lcdsb_ctrl_t;

endpackage : lcdsb_pkg

// ---- logic/lcdsb_top.sv ----
// LCD upper segment pin select, per-dot blink and display RAM with APB access
`timescale 1ns/1ps
`default_nettype none

module lcdsb_top #(
  parameter int unsigned ADDR_W         = 32,
  parameter int unsigned BLINK_FAST_CYC = lcdsb_pkg::LCDSB_BLINK_FAST_CYC,
  parameter int unsigned BLINK_SLOW_CYC = lcdsb_pkg::LCDSB_BLINK_SLOW_CYC
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              pce,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  input  wire logic [2:0]        com_sel,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  output logic      [31:0]       seg_on,
  output logic      [7:0]        seg_en
);

  localparam int unsigned RAM_N = lcdsb_pkg::LCDSB_RAM_BYTES_8COM;

  lcdsb_pkg::lcdsb_ctrl_t ctrl_r, ctrl_nxt;
  logic [7:0]  pin_sel_r, pin_sel_nxt;
  logic [15:0] blink_r, blink_nxt;
  logic [7:0]  ram_r   [RAM_N];
  logic [7:0]  ram_nxt [RAM_N];
  logic [31:0] prdata_r, prdata_nxt;
  logic        pready_r, pready_nxt;
  logic        pslverr_r, pslverr_nxt;
  logic [31:0] seg_on_r, seg_on_nxt;
  logic [7:0]  seg_en_r, seg_en_nxt;
  logic [31:0] cnt_r, cnt_nxt;
  logic        phase_r, phase_nxt;
  logic [31:0] dot_w;
  logic [15:0] idx;
  logic [4:0]  ram_off;
  logic        wr;
  logic [31:0] rd_val;
  logic [31:0] limit;

  function automatic logic ram_hit(input logic [15:0] i);
    ram_hit = (i >= lcdsb_pkg::LCDSB_IDX_RAM_BASE) &&
              (i < lcdsb_pkg::LCDSB_IDX_RAM_BASE + 16'(RAM_N));
  endfunction : ram_hit

  function automatic logic mapped(input logic [15:0] i);
    mapped = ram_hit(i) ||
             i == lcdsb_pkg::LCDSB_IDX_BLINK_LO ||
             i == lcdsb_pkg::LCDSB_IDX_BLINK_HI ||
             i == lcdsb_pkg::LCDSB_IDX_PIN_SEL ||
             i == lcdsb_pkg::LCDSB_IDX_CTRL ||
             i == lcdsb_pkg::LCDSB_IDX_STATUS;
  endfunction : mapped

  // Returns the blink enable that owns a dot, zero if none
  function automatic logic blink_owner(input logic        fc,
                                       input logic [4:0]  s,
                                       input logic [2:0]  c,
                                       input logic [15:0] en);
    logic [3:0] x;
    x = 4'h0;
    blink_owner = 1'b0;
    if (fc)
    begin
      if (s < 5'd4 && c < 3'd4)
      begin
        x = {s[1:0], c[1:0]};
        blink_owner = en[x];
      end
    end
    else if (s < 5'd2)
    begin
      x = {s[0], c};
      blink_owner = en[x];
    end
  endfunction : blink_owner

  assign idx     = paddr[17:2];
  assign ram_off = 5'(idx - lcdsb_pkg::LCDSB_IDX_RAM_BASE);
  assign wr      = psel && penable && pwrite && pready_r && !pslverr_r;
  assign limit   = ctrl_r.blink_interval_select ? 32'(BLINK_SLOW_CYC)
                                                : 32'(BLINK_FAST_CYC);

  // Dot level for each segment at the current common
  genvar g;
  generate
    for (g = 0; g < 32; g++)
    begin : g_seg
      logic raw8;
      logic raw4;
      if (g < RAM_N)
      begin : g_r8
        assign raw8 = ram_r[g][com_sel];
      end
      else
      begin : g_z8
        assign raw8 = 1'b0;
      end
      // Low nibble feeds the even segment, high nibble the odd one
      assign raw4 = (com_sel < 3'd4) &&
                    ram_r[g/2][(g%2)*4 + com_sel[1:0]];
      // Blink off phase forces unselected even over a RAM 1
      assign dot_w[g] = (ctrl_r.four_com ? raw4 : raw8) &&
                        !(!phase_r && blink_owner(ctrl_r.four_com,
                          5'(g), com_sel, blink_r));
    end
  endgenerate

  always_comb
  begin
    rd_val = 32'h0;
    if (ram_hit(idx))
      rd_val = {24'h0, ram_r[ram_off]};
    else
      case (idx)
        lcdsb_pkg::LCDSB_IDX_BLINK_LO: rd_val = {24'h0, blink_r[7:0]};
        lcdsb_pkg::LCDSB_IDX_BLINK_HI: rd_val = {24'h0, blink_r[15:8]};
        lcdsb_pkg::LCDSB_IDX_PIN_SEL:  rd_val = {24'h0, pin_sel_r};
        lcdsb_pkg::LCDSB_IDX_CTRL:     rd_val = {29'h0, ctrl_r};
        lcdsb_pkg::LCDSB_IDX_STATUS:
        begin
          rd_val[lcdsb_pkg::LCDSB_STAT_PHASE_BIT] = phase_r;
          rd_val[lcdsb_pkg::LCDSB_STAT_SEG_EN_LSB +: 8] = seg_en_r;
        end
        default: rd_val = 32'h0;
      endcase
  end

  always_comb
  begin
    ctrl_nxt    = ctrl_r;
    pin_sel_nxt = pin_sel_r;
    blink_nxt   = blink_r;
    ram_nxt     = ram_r;
    prdata_nxt  = prdata_r;
    // Answer one cycle after setup so every bus output is a flop
    pready_nxt  = psel && !penable;
    pslverr_nxt = psel && !penable && !mapped(idx);
    if (psel && !penable && !pwrite)
      prdata_nxt = rd_val;
    if (wr && pstrb[0])
    begin
      if (ram_hit(idx))
        ram_nxt[ram_off] = pwdata[7:0];
      else
        case (idx)
          lcdsb_pkg::LCDSB_IDX_BLINK_LO: blink_nxt[7:0]  = pwdata[7:0];
          lcdsb_pkg::LCDSB_IDX_BLINK_HI: blink_nxt[15:8] = pwdata[7:0];
          lcdsb_pkg::LCDSB_IDX_PIN_SEL:
          begin
            pin_sel_nxt[3:0] = pwdata[3:0];
            if (ctrl_r.four_com)
              pin_sel_nxt[7:4] = pwdata[7:4];
          end
          lcdsb_pkg::LCDSB_IDX_CTRL: ctrl_nxt = pwdata[2:0];
          default: ctrl_nxt = ctrl_r;
        endcase
    end
  end

  // One shared timer gives every blinking dot the same phase
  always_comb
  begin
    cnt_nxt   = cnt_r + 32'h1;
    phase_nxt = phase_r;
    if (cnt_r >= limit - 32'h1)
    begin
      cnt_nxt   = 32'h0;
      phase_nxt = !phase_r;
    end
  end

  always_comb
  begin
    seg_on_nxt = dot_w;
    seg_en_nxt = 8'h0;
    if (ctrl_r.pin_interface_control)
    begin
      seg_en_nxt[3:0] = pin_sel_r[3:0];
      if (ctrl_r.four_com)
        seg_en_nxt[7:4] = pin_sel_r[7:4];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_r    <= lcdsb_pkg::LCDSB_RST_CTRL;
      pin_sel_r <= lcdsb_pkg::LCDSB_RST_BYTE;
      blink_r   <= {2{lcdsb_pkg::LCDSB_RST_BYTE}};
      for (int i = 0; i < RAM_N; i++)
        ram_r[i] <= lcdsb_pkg::LCDSB_RST_BYTE;
      prdata_r  <= 32'h0;
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      seg_on_r  <= 32'h0;
      seg_en_r  <= 8'h0;
      cnt_r     <= 32'h0;
      phase_r   <= 1'b1;
    end
    else if (pce)
    begin
      ctrl_r    <= ctrl_nxt;
      pin_sel_r <= pin_sel_nxt;
      blink_r   <= blink_nxt;
      ram_r     <= ram_nxt;
      prdata_r  <= prdata_nxt;
      pready_r  <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      seg_on_r  <= seg_on_nxt;
      seg_en_r  <= seg_en_nxt;
      cnt_r     <= cnt_nxt;
      phase_r   <= phase_nxt;
    end
  end

  assign prdata  = prdata_r;
  assign pready  = pready_r;
  assign pslverr = pslverr_r;
  assign seg_on  = seg_on_r;
  assign seg_en  = seg_en_r;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  hi_sel_ignored_a: assert property (
    (pce && wr && pstrb[0] && idx == lcdsb_pkg::LCDSB_IDX_PIN_SEL &&
     !ctrl_r.four_com) |=> $stable(pin_sel_r[7:4]))
    else $error("upper select bits changed in eight-common mode");
  hi_pins_four_a: assert property (
    (pce && ctrl_r.four_com && ctrl_r.pin_interface_control)
      |=> seg_en_r[7:4] == $past(pin_sel_r[7:4]))
    else $error("segment 28-31 enable wrong in four-common mode");
  lo_pins_both_a: assert property (
    (pce && ctrl_r.pin_interface_control)
      |=> seg_en_r[3:0] == $past(pin_sel_r[3:0]))
    else $error("segment 24-27 enable wrong");
  pin_if_gate_a: assert property (
    (pce && !ctrl_r.pin_interface_control) |=> seg_en_r == 8'h0)
    else $error("segment enables active without pin interface");
  blink_write_a: assert property (
    (pce && wr && pstrb[0] && idx == lcdsb_pkg::LCDSB_IDX_BLINK_HI)
      |=> blink_r[15:8] == $past(pwdata[7:0]))
    else $error("blink high register not written");
  blink_timer_a: assert property (
    (pce && $past(pce) && phase_r != $past(phase_r))
      |-> $past(cnt_r) >= $past(limit) - 32'h1)
    else $error("blink phase toggled before interval");
  blink_ram_one_a: assert property (
    (pce && !ctrl_r.four_com && ram_r[0][com_sel] &&
     blink_r[{1'b0, com_sel}] && !phase_r) |=> !seg_on_r[0])
    else $error("blinking dot shown during off phase");
  ram_follow_a: assert property (
    (pce && !ctrl_r.four_com) |=> seg_on_r[5] == $past(ram_r[5][com_sel]))
    else $error("segment 5 does not follow display RAM");
  nibble_map_a: assert property (
    (pce && ctrl_r.four_com && com_sel < 3'd4)
      |=> seg_on_r[9] == $past(ram_r[4][4 + com_sel[1:0]]))
    else $error("odd segment not taken from high nibble");
  no_seg28_a: assert property (
    (pce && !ctrl_r.four_com) |=> seg_on_r[31:28] == 4'h0)
    else $error("segments beyond 27 driven in eight-common mode");

  apb_read_c:  cover property (psel && penable && pready_r && !pwrite);
  blink_flip_c: cover property (pce && phase_r != $past(phase_r));
  four_pin_c:  cover property (ctrl_r.four_com && seg_en_r[7]);
  blink_dot_c: cover property (blink_r[3] && !phase_r && ram_r[0][3]);

endmodule : lcdsb_top

`default_nettype wire

// ---- sim/lcdsb_panel_model.sv ----
// LCD panel model: keeps the dot pattern seen on each scanned common
`timescale 1ns/1ps
`default_nettype none
module lcdsb_panel_model (
  input  wire logic         pclk,
  input  wire logic [2:0]   com_sel,
  input  wire logic [31:0]  seg_on,
  output var  logic [255:0] lit
);
  logic [2:0] com_q = 3'h0;

  // Segment outputs lag the common by one cycle, so pair with the old one
  always @(posedge pclk)
  begin
    com_q <= com_sel;
    lit[com_q*32 +: 32] <= seg_on;
  end
endmodule : lcdsb_panel_model
`default_nettype wire

// ---- sim/tb_top.sv ----
// Testbench for upper segment select, dot blink and display RAM
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic         pclk = 1'b0;
  logic         presetn = 1'b0;
  logic         psel = 1'b0;
  logic         penable = 1'b0;
  logic         pwrite = 1'b0;
  logic [31:0]  paddr = 32'h0;
  logic [31:0]  pwdata = 32'h0;
  logic [2:0]   com_sel = 3'h0;
  logic         pce = 1'b1;
  logic [3:0]   pstrb = 4'hf;
  logic [31:0]  prdata;
  logic         pready;
  logic         pslverr;
  logic [31:0]  seg_on;
  logic [7:0]   seg_en;
  logic [255:0] lit;
  logic [31:0]  rd;
  logic         er;
  int           fails = 0;
  int           comparisons = 0;

  always #5 pclk = ~pclk;

  // Short blink counts keep the run brief
  lcdsb_top #(.BLINK_FAST_CYC(4), .BLINK_SLOW_CYC(8)) dut_u (
    .pclk(pclk), .presetn(presetn), .pce(pce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .com_sel(com_sel), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .seg_on(seg_on), .seg_en(seg_en));

  lcdsb_panel_model panel_u (
    .pclk(pclk), .com_sel(com_sel), .seg_on(seg_on), .lit(lit));

  task automatic give_verdict;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string what);
    comparisons++;
    if (got !== exp)
    begin
      fails++;
      $display("Error %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  // One APB transfer; enters and leaves just after a rising edge, with an
  // idle cycle at the end so psel is never driven twice in one time step
  task automatic apb(input logic w, input logic [15:0] idx,
                     input logic [7:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {14'h0, idx, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20)
    begin
      @(posedge pclk);
      n++;
    end
    if (pready !== 1'b1)
    begin
      fails++;
      $display("Error %0t: no pready", $time);
      give_verdict();
    end
    else
    begin
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
    end
  endtask : apb

  // Hold one common long enough for the panel to latch it
  task automatic scan(input logic [2:0] c);
    com_sel <= c;
    repeat (3) @(posedge pclk);
  endtask : scan

  // Count lit cycles and phase changes of segment 1; unknowns count as dark
  task automatic watch(input int n, output int ones, output int tr);
    logic last;
    ones = 0;
    tr = 0;
    last = seg_on[1];
    repeat (n)
    begin
      @(posedge pclk);
      if (seg_on[0] !== seg_on[1])
        chk({31'h0, seg_on[0]}, {31'h0, seg_on[1]}, "phase");
      ones += (seg_on[1] === 1'b1) ? 1 : 0;
      tr += (seg_on[1] !== last) ? 1 : 0;
      last = seg_on[1];
    end
  endtask : watch

  task automatic t_regs;
    apb(1'b0, lcdsb_pkg::LCDSB_IDX_BLINK_LO, 8'h00);
    chk(rd, 32'h0, "blink low reset");
    apb(1'b0, lcdsb_pkg::LCDSB_IDX_BLINK_HI, 8'h00);
    chk(rd, 32'h0, "blink high reset");
    apb(1'b1, lcdsb_pkg::LCDSB_IDX_BLINK_LO, 8'h5a);
    apb(1'b1, lcdsb_pkg::LCDSB_IDX_BLINK_HI, 8'ha5);
    apb(1'b0, lcdsb_pkg::LCDSB_IDX_BLINK_LO, 8'h00);
    chk(rd, 32'h5a, "blink low rw");
    apb(1'b0, lcdsb_pkg::LCDSB_IDX_BLINK_HI, 8'h00);
    chk(rd, 32'ha5, "blink high rw");
    pstrb <= 4'h0;
    apb(1'b1, lcdsb_pkg::LCDSB_IDX_BLINK_LO, 8'hff);
    pstrb <= 4'hf;
    apb(1'b0, lcdsb_pkg::LCDSB_IDX_BLINK_LO, 8'h00);
    chk(rd, 32'h5a, "strobe off");
    apb(1'b0, 16'h0fff, 8'h00);
    chk({31'h0, er}, 32'h1, "unmapped");
    apb(1'b1, lcdsb_pkg::LCDSB_IDX_BLINK_LO, 8'h00);
    apb(1'b1, lcdsb_pkg::LCDSB_IDX_BLINK_HI, 8'h00);
    $display("test regs done");
  endtask : t_regs

  // Pin enables settle one cycle after the register write lands
  task automatic t_pins;
    apb(1'b1, lcdsb_pkg::LCDSB_IDX_CTRL, 8'h02);
    apb(1'b1, lcdsb_pkg::LCDSB_IDX_PIN_SEL, 8'hff);
    apb(1'b0, lcdsb_pkg::LCDSB_IDX_PIN_SEL, 8'h00);
    chk(rd, 32'h0f, "upper bits kept");
    @(posedge pclk);
    chk({24'h0, seg_en}, 32'h0f, "8com pins");
    apb(1'b1, lcdsb_pkg::LCDSB_IDX_CTRL, 8'h03);
    apb(1'b1, lcdsb_pkg::LCDSB_IDX_PIN_SEL, 8'ha5);
    @(posedge pclk);
    chk({24'h0, seg_en}, 32'ha5, "4com pins");
    apb(1'b0, lcdsb_pkg::LCDSB_IDX_STATUS, 8'h00);
    chk({24'h0, rd[15:8]}, 32'ha5, "status pins");
    apb(1'b1, lcdsb_pkg::LCDSB_IDX_CTRL, 8'h01);
    @(posedge pclk);
    chk({24'h0, seg_en}, 32'h0, "pin if off");
    $display("test pins done");
  endtask : t_pins

  task automatic t_ram;
    apb(1'b1, lcdsb_pkg::LCDSB_IDX_CTRL, 8'h00);
    apb(1'b1, lcdsb_pkg::LCDSB_IDX_RAM_BASE + 16'd27, 8'h04);
    scan(3'h2);
    chk(lit[64 +: 32], 32'h0800_0000, "8com seg 27");
    scan(3'h3);
    chk(lit[96 +: 32], 32'h0, "8com dark");
    apb(1'b1, lcdsb_pkg::LCDSB_IDX_CTRL, 8'h01);
    apb(1'b1, lcdsb_pkg::LCDSB_IDX_RAM_BASE + 16'd15, 8'h20);
    scan(3'h1);
    chk(lit[32 +: 32], 32'h8000_0000, "4com seg 31");
    $display("test ram done");
  endtask : t_ram

  // Windows are whole blink periods, so duty and toggle counts are exact
  task automatic t_blink;
    int ones;
    int tr;
    apb(1'b1, lcdsb_pkg::LCDSB_IDX_CTRL, 8'h00);
    apb(1'b1, lcdsb_pkg::LCDSB_IDX_RAM_BASE, 8'h08);
    apb(1'b1, lcdsb_pkg::LCDSB_IDX_RAM_BASE + 16'd1, 8'h08);
    apb(1'b1, lcdsb_pkg::LCDSB_IDX_BLINK_LO, 8'h08);
    apb(1'b1, lcdsb_pkg::LCDSB_IDX_BLINK_HI, 8'h08);
    scan(3'h3);
    watch(32, ones, tr);
    chk(ones, 16, "fast duty");
    chk(tr, 8, "fast rate");
    apb(1'b1, lcdsb_pkg::LCDSB_IDX_CTRL, 8'h04);
    watch(16, ones, tr);
    watch(32, ones, tr);
    chk(ones, 16, "slow duty");
    chk(tr, 4, "slow rate");
    apb(1'b1, lcdsb_pkg::LCDSB_IDX_CTRL, 8'h01);
    apb(1'b1, lcdsb_pkg::LCDSB_IDX_RAM_BASE, 8'h88);
    apb(1'b1, lcdsb_pkg::LCDSB_IDX_BLINK_LO, 8'h88);
    watch(16, ones, tr);
    watch(32, ones, tr);
    chk(ones, 16, "4com duty");
    chk(tr, 8, "4com rate");
    $display("test blink done");
  endtask : t_blink

  // Clock enable low must freeze the blinking outputs
  task automatic t_hold;
    logic [31:0] frozen;
    int          k;
    pce <= 1'b0;
    @(posedge pclk);
    frozen = seg_on;
    for (k = 0; k < 12; k++)
    begin
      @(posedge pclk);
      chk(seg_on, frozen, "frozen");
    end
    pce <= 1'b1;
    @(posedge pclk);
    $display("test hold done");
  endtask : t_hold

  initial
  begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    t_pins();
    t_ram();
    t_blink();
    t_hold();
    give_verdict();
  end
endmodule : tb_top
`default_nettype wire
